// >>> core/reset_cause_pkg.sv
// Constants, types and register map of the reset-cause and oscillator block.
package reset_cause_pkg;

  localparam int unsigned CORE_CLK_MHZ = 200;
  localparam int unsigned RST_DELAY_US         = 18000;
  localparam int unsigned RST_DELAY_CYCLES_NOM = RST_DELAY_US * CORE_CLK_MHZ;
  localparam int unsigned RST_DELAY_CNT_W      = 22;

  localparam logic [7:0] STATUS_ADDR     = 8'h03;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_ADDR  = 8'h11;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h12;
  localparam logic [7:0] CAUSE_ADDR      = 8'h13;
  localparam logic [7:0] OSC_MODE_ADDR   = 8'h14;

  localparam int unsigned TIMEOUT_BIT   = 4;
  localparam int unsigned POWERDOWN_BIT = 3;
  localparam logic [7:0]  STATUS_POR      = 8'h18;
  localparam logic [7:0]  STATUS_KEEP_MSK = 8'h07;
  localparam logic [7:0]  STATUS_WR_MSK   = 8'he7;

  localparam int unsigned IRQ_W    = 4;
  localparam int unsigned EV_POR   = 0;
  localparam int unsigned EV_CLEAR    = 1;
  localparam int unsigned EV_WATCHDOG = 2;
  localparam int unsigned EV_WAKE  = 3;
  localparam logic [3:0]  IRQ_STATUS_POR = 4'h1;

  typedef enum logic [1:0] {
    low_power_crystal_mode  = 2'h0,
    crystal_resonator_mode  = 2'h1,
    high_speed_crystal_mode = 2'h2,
    rc_osc_mode             = 2'h3
  } osc_mode_t;

  typedef enum logic [1:0] {
    st_hold  = 2'h0,
    st_timer = 2'h1,
    st_run   = 2'h3
  } reset_fsm_t;

  typedef enum logic [2:0] {
    cause_none      = 3'h0,
    cause_por       = 3'h1,
    cause_clear          = 3'h2,
    cause_clear_wake     = 3'h3,
    cause_watchdog       = 3'h4,
    cause_watchdog_wake  = 3'h5
  } cause_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wr_data;
  } reg_req_t;

  typedef struct packed {
    logic                 clr_meta;
    logic                 clr_sync;
    logic                 clr_prev;
    logic                 osc_meta;
    logic                 osc_sync;
    logic                 osc_prev;
    logic                 osc_tick;
    logic [1:0]           q_phase;
    reset_fsm_t           fsm;
    logic [RST_DELAY_CNT_W-1:0] delay_cnt;
    logic [7:0]           status;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_enable;
    cause_t               cause;
    logic [7:0]           rd_data;
  } state_t;

endpackage : reset_cause_pkg

// >>> core/reset_cause_and_osc_mode.sv
// Reset sequencing, reset-cause flags and oscillator-mode clock output.
//
// What this block does
// [R1] Two-bit field selects one of four oscillator modes.
// [R2] Crystal modes accept external clock on input pin.
// [R3] RC mode drives oscillator divided by four out.
// [R4] Five reset causes: power-on, clear, wake, watchdog.
// [R5] Unreset registers keep contents through non-power resets.
// [R6] Reset-state registers load on every reset kind.
// [R7] Wake-up from sleep performs a full reset.
// [R8] Timeout and powerdown flags sit in status bits 4:3.
// [R9] Flags per cause: 11, uu, 10, 01, 00.
// [R10] Status at 03h: page bits, flags, zero, carries.
// [R11] Status loads 0001 1xxx or 000q quuu.
// [R12] Reset timer holds processor for nominal 18 ms.
// [R13] Timer starts on watchdog or master clear release.
// [R14] Master clear input is active low.
// [R15] Mode field encoding is a design parameter.
module reset_cause_and_osc_mode
  import reset_cause_pkg::*;
#(
  parameter int unsigned RST_DELAY_CYCLES = RST_DELAY_CYCLES_NOM,
  parameter logic [1:0]  LOWPWR_CODE      = 2'h0,
  parameter logic [1:0]  XTAL_CODE        = 2'h1,
  parameter logic [1:0]  HISPEED_CODE     = 2'h2,
  parameter logic [1:0]  RC_CODE          = 2'h3
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [1:0] osc_select_field,
  input  wire logic       master_clear_n,
  input  wire logic       watchdog_timeout,
  input  wire logic       sleep_active,
  input  wire logic       osc_input_pin,
  output logic            osc_output_pin,
  output logic            osc_output_oe,
  output logic            osc_tick,
  output logic [1:0]      q_phase,
  output logic            cpu_reset,
  input  wire reg_req_t   bus_req,
  output logic [7:0]      bus_rd_data,
  output logic            irq
);

  // The watchdog restart check expects at least eight held cycles.
  if (RST_DELAY_CYCLES < 8 ||
      RST_DELAY_CYCLES >= (2 ** RST_DELAY_CNT_W)) begin : g_bad_delay
    $error("Reset delay does not fit the reset timer counter");
  end
  if (LOWPWR_CODE == XTAL_CODE || LOWPWR_CODE == HISPEED_CODE ||
      LOWPWR_CODE == RC_CODE || XTAL_CODE == HISPEED_CODE ||
      XTAL_CODE == RC_CODE || HISPEED_CODE == RC_CODE)
  begin : g_bad_codes
    $error("Oscillator mode codes must be distinct");
  end

  localparam logic [RST_DELAY_CNT_W-1:0] RST_DELAY_LAST =
    RST_DELAY_CNT_W'(RST_DELAY_CYCLES - 1);

  // The field encoding is left open, so it maps through parameters.
  function automatic osc_mode_t decode_mode(input logic [1:0] field);
    osc_mode_t m;
    m = rc_osc_mode;
    if (field == LOWPWR_CODE) m = low_power_crystal_mode;
    else if (field == XTAL_CODE) m = crystal_resonator_mode;
    else if (field == HISPEED_CODE) m = high_speed_crystal_mode;
    return m;
  endfunction : decode_mode

  // Timeout and powerdown values per cause; plain master clear keeps them.
  function automatic logic [1:0] flags_for(input cause_t c,
                                           input logic [1:0] old);
    logic [1:0] f;
    f = old;
    case (c)
      cause_por:       f = 2'h3;
      cause_clear_wake:    f = 2'h2;
      cause_watchdog:      f = 2'h1;
      cause_watchdog_wake: f = 2'h0;
      default:         f = old;
    endcase
    return f;
  endfunction : flags_for

  state_t     s_q;
  state_t     s_d;
  osc_mode_t  mode;
  logic       crystal_mode;
  logic       clear_evt;
  logic       watchdog_evt;
  logic       reset_evt;
  cause_t     evt_cause;
  logic [1:0] new_flags;
  logic [IRQ_W-1:0] events;

  always_comb begin
    mode         = decode_mode(osc_select_field); // R1 R15
    crystal_mode = (mode != rc_osc_mode);
    clear_evt    = s_q.clr_prev && !s_q.clr_sync; // R14
    watchdog_evt = watchdog_timeout && (s_q.fsm != st_hold);
    reset_evt    = clear_evt || watchdog_evt; // R4
    if (clear_evt) begin
      evt_cause = sleep_active ? cause_clear_wake : cause_clear;
    end else if (watchdog_evt) begin
      evt_cause = sleep_active ? cause_watchdog_wake : cause_watchdog;
    end else begin
      evt_cause = cause_none;
    end
    new_flags = flags_for(evt_cause,
                          s_q.status[TIMEOUT_BIT:POWERDOWN_BIT]); // R9
    events = '0;
    events[EV_CLEAR]    = clear_evt;
    events[EV_WATCHDOG] = watchdog_evt;
    events[EV_WAKE] = reset_evt && sleep_active;
  end

  always_comb begin
    s_d = s_q;
    s_d.rd_data = '0;

    // Only the second and third stages of each synchroniser feed any logic.
    s_d.clr_meta  = master_clear_n;
    s_d.clr_sync  = s_q.clr_meta;
    s_d.clr_prev  = s_q.clr_sync;
    s_d.osc_meta  = osc_input_pin;
    s_d.osc_sync  = s_q.osc_meta;
    s_d.osc_prev  = s_q.osc_sync;

    // In RC mode the core clock stands for the RC oscillator itself.
    s_d.osc_tick = crystal_mode ? (s_q.osc_sync && !s_q.osc_prev)
                                : 1'b1; // R2
    if (s_d.osc_tick) begin
      s_d.q_phase = s_q.q_phase + 2'h1; // R3
    end

    // Reset timer: hold while the pin is low, count after release.
    if (!s_q.clr_sync) begin
      s_d.fsm       = st_hold; // R14
      s_d.delay_cnt = '0;
    end else begin
      case (s_q.fsm)
        st_hold: begin
          s_d.fsm       = st_timer; // R13
          s_d.delay_cnt = '0;
        end
        st_timer: begin
          if (watchdog_evt) begin
            s_d.delay_cnt = '0; // R13
          end else if (s_q.delay_cnt == RST_DELAY_LAST) begin
            s_d.fsm = st_run; // R12
          end else begin
            s_d.delay_cnt = s_q.delay_cnt + RST_DELAY_CNT_W'(1); // R12
          end
        end
        st_run: begin
          if (watchdog_evt) begin
            s_d.fsm       = st_timer; // R13 R7
            s_d.delay_cnt = '0;
          end
        end
        default: begin
          s_d.fsm       = st_hold;
          s_d.delay_cnt = '0;
        end
      endcase
    end

    // Software writes reach page bits and the arithmetic flags only.
    if (bus_req.wr_en && bus_req.addr == STATUS_ADDR) begin
      s_d.status = (s_q.status & ~STATUS_WR_MSK) |
                   (bus_req.wr_data & STATUS_WR_MSK); // R8 R10
    end
    // A reset in the same cycle overrides the software write.
    if (reset_evt) begin
      s_d.status = (s_q.status & STATUS_KEEP_MSK); // R11 R5 R6
      s_d.status[TIMEOUT_BIT:POWERDOWN_BIT] = new_flags; // R9 R8
      s_d.cause  = evt_cause;
    end

    if (bus_req.wr_en && bus_req.addr == IRQ_ENABLE_ADDR) begin
      s_d.irq_enable = bus_req.wr_data[IRQ_W-1:0];
    end
    // New events win over a clear in the same cycle.
    s_d.irq_status = s_q.irq_status | events;
    if (bus_req.wr_en && bus_req.addr == IRQ_CLEAR_ADDR) begin
      s_d.irq_status = (s_q.irq_status & ~bus_req.wr_data[IRQ_W-1:0]) |
                       events;
    end

    if (bus_req.rd_en) begin
      case (bus_req.addr)
        STATUS_ADDR:     s_d.rd_data = s_q.status; // R10
        IRQ_STATUS_ADDR: s_d.rd_data = 8'(s_q.irq_status);
        IRQ_ENABLE_ADDR: s_d.rd_data = 8'(s_q.irq_enable);
        CAUSE_ADDR:      s_d.rd_data = 8'(s_q.cause);
        OSC_MODE_ADDR:   s_d.rd_data = 8'(mode);
        default:         s_d.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Power-on leaves the arithmetic flags undefined; zero is chosen.
      s_q            <= '0;
      s_q.fsm        <= st_hold;
      s_q.status     <= STATUS_POR; // R11 R9 R6
      s_q.cause      <= cause_por;
      s_q.irq_status <= IRQ_STATUS_POR;
    end else begin
      s_q <= s_d;
    end
  end

  assign osc_output_oe  = (mode == rc_osc_mode); // R3
  assign osc_output_pin = osc_output_oe && s_q.q_phase[1]; // R3
  assign osc_tick       = s_q.osc_tick;
  assign q_phase        = s_q.q_phase;
  assign cpu_reset      = (s_q.fsm != st_run); // R12 R7
  assign bus_rd_data    = s_q.rd_data;
  assign irq            = |(s_q.irq_status & s_q.irq_enable);

  sequence s_clkout_high_then_low;
    osc_output_pin [*2] ##1 !osc_output_pin [*2] ##1 osc_output_pin;
  endsequence

  sequence s_timer_hold;
    cpu_reset [*8];
  endsequence

  property p_rc_oe;
    @(posedge core_clk) disable iff (rst)
      osc_output_oe == (osc_select_field == RC_CODE);
  endproperty
  a_rc_oe: assert property (p_rc_oe) // R3
    else $error("clock output enable does not follow RC mode");

  property p_clkout_div4;
    @(posedge core_clk) disable iff (rst || osc_select_field != RC_CODE)
      $rose(s_q.q_phase[1]) |-> s_clkout_high_then_low;
  endproperty
  a_clkout_div4: assert property (p_clkout_div4) // R3
    else $error("clock output is not the oscillator divided by four");

  property p_por_status;
    @(posedge core_clk) rst |=> (bus_rd_data == 8'h00) &&
      (s_q.status[7:3] == STATUS_POR[7:3]) && cpu_reset;
  endproperty
  a_por_status: assert property (p_por_status) // R11
    else $error("power-on status value wrong");

  property p_watchdog_normal_flags;
    @(posedge core_clk) disable iff (rst)
      watchdog_evt && !clear_evt && !sleep_active |=>
        s_q.status[TIMEOUT_BIT:POWERDOWN_BIT] == 2'h1 &&
        s_q.status[7:5] == 3'h0;
  endproperty
  a_watchdog_normal_flags: assert property (p_watchdog_normal_flags) // R9
    else $error("watchdog reset flags wrong");

  property p_watchdog_wake_flags;
    @(posedge core_clk) disable iff (rst)
      watchdog_evt && !clear_evt && sleep_active |=>
        s_q.status[TIMEOUT_BIT:POWERDOWN_BIT] == 2'h0 && cpu_reset;
  endproperty
  a_watchdog_wake_flags: assert property (p_watchdog_wake_flags) // R9
    else $error("watchdog wake-up flags wrong");

  // Sleep is judged in the event cycle, so look back at it.
  property p_clear_flags;
    @(posedge core_clk) disable iff (rst)
      clear_evt |=> ($past(sleep_active) ?
        s_q.status[TIMEOUT_BIT:POWERDOWN_BIT] == 2'h2 :
        $stable(s_q.status[TIMEOUT_BIT:POWERDOWN_BIT]));
  endproperty
  a_clear_flags: assert property (p_clear_flags) // R9
    else $error("master clear flags wrong");

  property p_flags_not_writable;
    @(posedge core_clk) disable iff (rst)
      bus_req.wr_en && !reset_evt |=>
        $stable(s_q.status[TIMEOUT_BIT:POWERDOWN_BIT]);
  endproperty
  a_flags_not_writable: assert property (p_flags_not_writable) // R8
    else $error("software changed a cause flag");

  property p_clear_holds;
    @(posedge core_clk) disable iff (rst)
      !s_q.clr_sync |=> cpu_reset;
  endproperty
  a_clear_holds: assert property (p_clear_holds) // R14
    else $error("processor left reset while master clear low");

  property p_watchdog_restarts_timer;
    @(posedge core_clk) disable iff (rst)
      watchdog_evt |=> s_timer_hold;
  endproperty
  a_watchdog_restarts_timer: assert property (p_watchdog_restarts_timer) // R13
    else $error("watchdog did not restart the reset timer");

  property p_release_after_timer;
    @(posedge core_clk) disable iff (rst)
      s_q.fsm == st_timer && s_q.delay_cnt == RST_DELAY_LAST &&
      s_q.clr_sync && !watchdog_evt |=> !cpu_reset;
  endproperty
  a_release_after_timer: assert property (p_release_after_timer) // R12
    else $error("reset not released when the timer expired");

  property p_clear_keeps_event;
    @(posedge core_clk) disable iff (rst)
      watchdog_evt |=> s_q.irq_status[EV_WATCHDOG];
  endproperty
  a_clear_keeps_event: assert property (p_clear_keeps_event) // R4
    else $error("watchdog event lost from interrupt status");

endmodule : reset_cause_and_osc_mode

// >>> sim/osc_clear_source.sv
// Model of the external clock source and the master-clear switch.
module osc_clear_source (
  input  wire logic       core_clk,
  input  wire logic       clk_run,
  input  wire logic [3:0] half_period,
  input  wire logic       press_clear,
  output logic            osc_input_pin,
  output logic            master_clear_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_q;
  initial begin
    osc_input_pin = 1'b0;
    master_clear_n = 1'b0;
    cnt_q = 4'h0;
  end
  // The switch pulls the line low, so a press asserts the device reset.
  always @(posedge core_clk) master_clear_n <= !press_clear;
  // A stopped source parks the pin low rather than leaving it at random.
  always @(posedge core_clk) begin
    if (!clk_run) begin
      osc_input_pin <= 1'b0;
      cnt_q <= 4'h0;
    end else if (cnt_q >= half_period - 4'h1) begin
      cnt_q <= 4'h0;
      osc_input_pin <= !osc_input_pin;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : osc_clear_source

// >>> sim/reset_cause_and_osc_mode_tb.sv
// Self-checking bench of the reset-cause and oscillator-mode block.
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module reset_cause_and_osc_mode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import reset_cause_pkg::*;
  localparam int unsigned DELAY_CYC = 20;
  localparam logic [3:0] BY_WD = 4'b0101;
  localparam logic [3:0] SLP = 4'b0110;
  localparam logic [1:0] FLG [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  localparam cause_t CSE [4] = '{cause_watchdog, cause_clear_wake,
                                 cause_watchdog_wake, cause_clear};
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] osc_select_field = 2'h0;
  logic       watchdog_timeout = 1'b0;
  logic       sleep_active = 1'b0;
  logic       press_clear = 1'b1;
  logic       rd_pend = 1'b0;
  logic       osc_input_pin, master_clear_n, osc_output_pin, osc_output_oe;
  logic       osc_tick, cpu_reset, irq, prev_pin;
  logic [1:0] q_phase, ph;
  logic [1:0] flags = 2'h3;
  logic [7:0] bus_rd_data, w, ev;
  logic [7:0] exp_q[$];
  reg_req_t   bus_req = '0;
  int         n_errors = 0;
  int         compares = 0;
  int         n, ticks, rises;
  integer     seed = 32'he8158c05;

  always #2.5 core_clk = ~core_clk;

  reset_cause_and_osc_mode #(
    .RST_DELAY_CYCLES(DELAY_CYC)
  ) reset_cause_and_osc_mode_inst (
    .core_clk        (core_clk),
    .rst             (rst),
    .osc_select_field(osc_select_field),
    .master_clear_n  (master_clear_n),
    .watchdog_timeout(watchdog_timeout),
    .sleep_active    (sleep_active),
    .osc_input_pin   (osc_input_pin),
    .osc_output_pin  (osc_output_pin),
    .osc_output_oe   (osc_output_oe),
    .osc_tick        (osc_tick),
    .q_phase         (q_phase),
    .cpu_reset       (cpu_reset),
    .bus_req         (bus_req),
    .bus_rd_data     (bus_rd_data),
    .irq             (irq)
  );

  osc_clear_source osc_clear_source_inst (
    .core_clk      (core_clk),
    .clk_run       (1'b1),
    .half_period   (4'h3),
    .press_clear   (press_clear),
    .osc_input_pin (osc_input_pin),
    .master_clear_n(master_clear_n)
  );

  // Read data stands only in the cycle after the strobe, so compare there.
  always @(posedge core_clk) begin
    if (rd_pend && exp_q.size() > 0) begin
      ev = exp_q.pop_front();
      `CHK(bus_rd_data, ev)
    end
    rd_pend <= bus_req.rd_en;
  end

  task automatic test_done;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{a, 1'b1, 1'b0, d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    exp_q.push_back(e);
    bus_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge core_clk);
    bus_req <= '0;
  endtask : rd

  task automatic wait_run;
    n = 0;
    while (cpu_reset !== 1'b0) begin
      @(negedge core_clk);
      n++;
      if (n > 500) begin
        n_errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, cpu_reset, 1'b0);
        test_done();
      end
    end
  endtask : wait_run

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK(cpu_reset, 1'b1)
    rd(STATUS_ADDR, STATUS_POR);
    rd(CAUSE_ADDR, 8'h01);
    @(posedge core_clk);
    press_clear <= 1'b0;
    wait_run();
    `CHK((n >= DELAY_CYC) && (n <= DELAY_CYC + 8), 1'b1)
    $display("test power_on done");
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      wr(STATUS_ADDR, w);
      rd(STATUS_ADDR, {w[7:5], flags, w[2:0]});
      @(posedge core_clk);
      sleep_active <= SLP[i];
      if (BY_WD[i]) watchdog_timeout <= 1'b1;
      else press_clear <= 1'b1;
      @(posedge core_clk);
      watchdog_timeout <= 1'b0;
      repeat (5) @(posedge core_clk);
      press_clear <= 1'b0;
      sleep_active <= 1'b0;
      @(negedge core_clk);
      `CHK(cpu_reset, 1'b1)
      wait_run();
      `CHK(n <= DELAY_CYC + 8 && (BY_WD[i] || n >= DELAY_CYC), 1'b1)
      if (i != 3) flags = FLG[i];
      rd(STATUS_ADDR, {3'h0, flags, w[2:0]});
      rd(CAUSE_ADDR, {5'h0, CSE[i]});
    end
    $display("test reset_causes done");
    rd(IRQ_STATUS_ADDR, 8'h0f);
    `CHK(irq, 1'b0)
    wr(IRQ_ENABLE_ADDR, 8'h04);
    repeat (2) @(negedge core_clk);
    `CHK(irq, 1'b1)
    wr(IRQ_CLEAR_ADDR, 8'h04);
    repeat (2) @(negedge core_clk);
    `CHK(irq, 1'b0)
    rd(IRQ_STATUS_ADDR, 8'h0b);
    rd(8'h20, 8'h00);
    $display("test irq done");
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      osc_select_field <= 2'(m);
      rd(OSC_MODE_ADDR, 8'(m));
      ticks = 0;
      rises = 0;
      prev_pin = 1'b0;
      @(negedge core_clk);
      ph = q_phase;
      repeat (48) begin
        @(negedge core_clk);
        ticks += int'(osc_tick === 1'b1);
        rises += int'(osc_output_pin === 1'b1 && prev_pin === 1'b0);
        prev_pin = osc_output_pin;
      end
      `CHK(osc_output_oe, m == 3)
      // Forty-eight ticks bring the quadrature phase back to its start.
      if (m == 3) `CHK(q_phase, ph)
      `CHK(rises >= 11 * int'(m == 3) && rises <= 12 * int'(m == 3), 1'b1)
      `CHK(m == 3 || (ticks >= 7 && ticks <= 9), 1'b1)
    end
    $display("test osc_modes done");
    repeat (3) @(posedge core_clk);
    test_done();
  end
endmodule : reset_cause_and_osc_mode_tb
